// ---- pkg/dac_cfg_pkg.sv ----
// package for the input port and modulator configuration block
// assumes 8-bit register access over a simple serial-port write/read strobe
package dac_cfg_pkg;
  localparam logic [7:0] input_data_format_control_addr = 8'h02;
  localparam logic [7:0] modulation_control_addr        = 8'h03;
  localparam logic [7:0] clock_offset_adjust_addr       = 8'h05;
  localparam logic [7:0] hardware_revision_addr         = 8'h0d;
  localparam logic [7:0] reg_reset_value                = 8'h00;
  // input_data_format_control fields
  localparam int fmt_bit        = 7;
  localparam int one_port_bit   = 6;
  localparam int drive_bit      = 5;
  localparam int edge_pol_bit   = 4;
  localparam int clk_dir_bit    = 3;
  localparam int recovery_bit   = 2;
  localparam int lane_pol_bit   = 1;
  localparam int gray_bit       = 0;
  // modulation_control fields
  localparam int channel_bit    = 7;
  localparam int hilbert_bit    = 6;
  localparam int dual_bit       = 5;
  localparam int sideband_bit   = 4;
  localparam int mix_hi_bit     = 3;
  localparam int mix_lo_bit     = 2;
  // clock_offset_adjust fields
  localparam int offset_hi_bit  = 7;
  localparam int offset_lo_bit  = 4;
  // arbitrary revision value
  localparam logic [3:0] revision_default = 4'h1;

  typedef enum logic [1:0]
  {
    route_i    = 2'b00,
    route_q    = 2'b01,
    route_real = 2'b10,
    route_imag = 2'b11
  } route_t;

  typedef enum logic [1:0]
  {
    mix_off   = 2'b00,
    mix_half  = 2'b01,
    mix_quart = 2'b10,
    mix_eight = 2'b11
  } mix_t;

  typedef struct packed
  {
    logic sample_number_format;
    logic single_port_interleave;
    logic capture_edge_polarity;
    logic word_clock_direction;
    logic word_clock_recovery_enable;
    logic lane_strobe_polarity;
  } data_cfg_t;

  typedef struct packed
  {
    logic        valid;
    logic [15:0] i_word;
    logic [15:0] q_word;
  } iq_pair_t;
endpackage : dac_cfg_pkg

// ---- hw/dac_input_modulator_config.sv ----
// input data port, lane steering, modulator and output routing configuration
// assumes reg_wr/reg_rd strobes come from the serial port logic on mclk
`timescale 1ns/1ns
`default_nettype none

// How it works
// - format bit clear reads two's complement, set reads unsigned binary
// - single-port clear: I on port one, Q on port two; set: interleaved on one
// - polarity clear captures on rising edge, set on falling edge
// - direction clear: word clock is input; set: device drives it out
// - clock recovery runs only with word clock input and recovery bit set
// - strobe high means I, low means Q; lane polarity bit inverts this
// - dual and channel bits pick I, Q, real or imaginary output
// - four-bit clock offset is signed, +7 to -8, zero at reset
module dac_input_modulator_config #(
  parameter int unsigned word_width = 16,
  parameter int unsigned clk_div    = 4
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  input  wire logic                  link_clk,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  input  wire logic [word_width-1:0] port1_data,
  input  wire logic [word_width-1:0] port2_data,
  input  wire logic                  lane_select_strobe,
  input  wire logic                  word_clk_in,
  output logic                       word_clk_out,
  output logic                       word_clk_oe_b,
  output logic                       recovery_active,
  output logic signed [4:0]          word_clock_offset,
  output logic [1:0]                 mix_rate_select,
  output logic                       dual_channel_mixing,
  output logic                       sideband_reject_lower,
  output logic [word_width-1:0]      converter_word,
  output logic                       converter_valid
);
  logic [7:0] data_q, data_d, mod_q, mod_d, adj_q, adj_d, rdata_d;
  logic [7:0] div_q, div_d;
  logic       wclk_q, wclk_d;

  // register bank on mclk
  always_comb
  begin
    data_d = data_q;
    mod_d  = mod_q;
    adj_d  = adj_q;
    if (reg_wr)
    begin
      case (reg_addr)
        dac_cfg_pkg::input_data_format_control_addr: data_d = reg_wdata;
        dac_cfg_pkg::modulation_control_addr:        mod_d  = reg_wdata;
        dac_cfg_pkg::clock_offset_adjust_addr:       adj_d  = reg_wdata;
        default:                                     data_d = data_q;
      endcase
    end
    case (reg_addr)
      dac_cfg_pkg::input_data_format_control_addr: rdata_d = data_q;
      dac_cfg_pkg::modulation_control_addr:        rdata_d = mod_q;
      dac_cfg_pkg::clock_offset_adjust_addr:       rdata_d = adj_q;
      dac_cfg_pkg::hardware_revision_addr:
        rdata_d = {4'h0, dac_cfg_pkg::revision_default};
      default:                                     rdata_d = 8'h00;
    endcase
    if (!reg_rd)
      rdata_d = reg_rdata;
  end

  // device drives the word clock by dividing mclk when direction bit set
  always_comb
  begin
    div_d  = div_q + 8'h01;
    wclk_d = wclk_q;
    if (div_q == 8'(clk_div - 1))
    begin
      div_d  = 8'h00;
      wclk_d = ~wclk_q;
    end
    if (!data_q[dac_cfg_pkg::clk_dir_bit])
      wclk_d = 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      data_q    <= dac_cfg_pkg::reg_reset_value;
      mod_q     <= dac_cfg_pkg::reg_reset_value;
      adj_q     <= dac_cfg_pkg::reg_reset_value;
      reg_rdata <= 8'h00;
      div_q     <= 8'h00;
      wclk_q    <= 1'b0;
    end
    else
    begin
      data_q    <= data_d;
      mod_q     <= mod_d;
      adj_q     <= adj_d;
      reg_rdata <= rdata_d;
      div_q     <= div_d;
      wclk_q    <= wclk_d;
    end
  end

  // configuration outputs, registered
  dac_cfg_pkg::data_cfg_t cfg;
  assign cfg = '{sample_number_format:       data_q[dac_cfg_pkg::fmt_bit],
                 single_port_interleave:     data_q[dac_cfg_pkg::one_port_bit],
                 capture_edge_polarity:      data_q[dac_cfg_pkg::edge_pol_bit],
                 word_clock_direction:       data_q[dac_cfg_pkg::clk_dir_bit],
                 word_clock_recovery_enable: data_q[dac_cfg_pkg::recovery_bit],
                 lane_strobe_polarity:       data_q[dac_cfg_pkg::lane_pol_bit]};

  logic               rec_d, oe_d, dual_d, side_d;
  logic signed [4:0]  off_d;
  logic [1:0]         mix_d;
  always_comb
  begin
    rec_d  = cfg.word_clock_recovery_enable & ~cfg.word_clock_direction;
    oe_d   = ~cfg.word_clock_direction;
    off_d  = 5'(signed'(adj_q[dac_cfg_pkg::offset_hi_bit:dac_cfg_pkg::offset_lo_bit]));
    mix_d  = mod_q[dac_cfg_pkg::mix_hi_bit:dac_cfg_pkg::mix_lo_bit];
    dual_d = mod_q[dac_cfg_pkg::dual_bit];
    side_d = mod_q[dac_cfg_pkg::dual_bit] & mod_q[dac_cfg_pkg::sideband_bit];
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      recovery_active       <= 1'b0;
      word_clk_oe_b         <= 1'b1;
      word_clk_out          <= 1'b0;
      word_clock_offset     <= 5'sd0;
      mix_rate_select       <= 2'b00;
      dual_channel_mixing   <= 1'b0;
      sideband_reject_lower <= 1'b0;
    end
    else
    begin
      recovery_active       <= rec_d;
      word_clk_oe_b         <= oe_d;
      word_clk_out          <= wclk_q;
      word_clock_offset     <= off_d;
      mix_rate_select       <= mix_d;
      dual_channel_mixing   <= dual_d;
      sideband_reject_lower <= side_d;
    end
  end

  // reset leaves the link domain on a link edge, so no link flop sees release inside its setup
  logic [1:0] link_rst_s;
  logic       link_rst_b;
  always_ff @(posedge link_clk or negedge rst_b)
  begin
    if (!rst_b)
      link_rst_s <= 2'b00;
    else
      link_rst_s <= {link_rst_s[0], 1'b1};
  end
  assign link_rst_b = link_rst_s[1];

  // link domain: config crosses as slow levels through two flops
  logic [3:0] cfg_s1, cfg_s2;
  always_ff @(posedge link_clk or negedge link_rst_b)
  begin
    if (!link_rst_b)
    begin
      cfg_s1 <= 4'h0;
      cfg_s2 <= 4'h0;
    end
    else
    begin
      cfg_s1 <= {cfg.sample_number_format, cfg.single_port_interleave,
                 cfg.lane_strobe_polarity, cfg.capture_edge_polarity};
      cfg_s2 <= cfg_s1;
    end
  end

  // both edges capture; polarity bit picks which sample is used
  logic [word_width-1:0] rise_p1, rise_p2, fall_p1, fall_p2;
  logic                  rise_sel, fall_sel;
  always_ff @(posedge link_clk)
  begin
    rise_p1  <= port1_data;
    rise_p2  <= port2_data;
    rise_sel <= lane_select_strobe;
  end
  always_ff @(negedge link_clk)
  begin
    fall_p1  <= port1_data;
    fall_p2  <= port2_data;
    fall_sel <= lane_select_strobe;
  end

  function automatic logic [word_width-1:0] to_signed(input logic [word_width-1:0] w,
                                                      input logic unsigned_fmt);
    to_signed = unsigned_fmt ? {~w[word_width-1], w[word_width-2:0]} : w;
  endfunction : to_signed

  dac_cfg_pkg::iq_pair_t pair_q, pair_d;
  logic [word_width-1:0] p1, p2;
  logic                  sel_i;
  always_comb
  begin
    p1     = cfg_s2[0] ? fall_p1 : rise_p1;
    p2     = cfg_s2[0] ? fall_p2 : rise_p2;
    sel_i  = (cfg_s2[0] ? fall_sel : rise_sel) ^ cfg_s2[1];
    pair_d = pair_q;
    pair_d.valid = 1'b0;
    if (!cfg_s2[2])
    begin
      pair_d.i_word = 16'(to_signed(p1, cfg_s2[3]));
      pair_d.q_word = 16'(to_signed(p2, cfg_s2[3]));
      pair_d.valid  = 1'b1;
    end
    else if (sel_i)
      pair_d.i_word = 16'(to_signed(p1, cfg_s2[3]));
    else
    begin
      pair_d.q_word = 16'(to_signed(p1, cfg_s2[3]));
      pair_d.valid  = 1'b1;
    end
  end
  always_ff @(posedge link_clk or negedge link_rst_b)
  begin
    if (!link_rst_b)
      pair_q <= '0;
    else
      pair_q <= pair_d;
  end

  // pair crosses to mclk by toggle handshake; a new pair is taken only once mclk has echoed
  // the last toggle, so hold never moves while mclk reads it; pairs arriving faster are dropped
  logic        tog_q, tog_d, take;
  logic [1:0]  ack_s;
  logic [2:0]  tog_s;
  logic [15:0] hold_i, hold_q;
  always_comb
  begin
    take  = pair_q.valid & (tog_q == ack_s[1]);
    tog_d = tog_q ^ take;
  end
  always_ff @(posedge link_clk or negedge link_rst_b)
  begin
    if (!link_rst_b)
    begin
      tog_q  <= 1'b0;
      ack_s  <= 2'b00;
      hold_i <= 16'h0000;
      hold_q <= 16'h0000;
    end
    else
    begin
      tog_q <= tog_d;
      ack_s <= {ack_s[0], tog_s[2]};
      if (take)
      begin
        hold_i <= 16'(pair_q.i_word);
        hold_q <= 16'(pair_q.q_word);
      end
    end
  end

  logic [word_width-1:0] conv_d;
  logic                  cv_d;
  dac_cfg_pkg::route_t   route;
  always_comb
  begin
    route  = dac_cfg_pkg::route_t'({mod_q[dac_cfg_pkg::dual_bit],
                                    mod_q[dac_cfg_pkg::channel_bit]});
    cv_d   = tog_s[2] ^ tog_s[1];
    conv_d = converter_word;
    if (cv_d)
    begin
      case (route)
        dac_cfg_pkg::route_i:    conv_d = word_width'(hold_i);
        dac_cfg_pkg::route_q:    conv_d = word_width'(hold_q);
        // mixer datapath lives downstream; real/imag taps are the I and Q lanes
        dac_cfg_pkg::route_real: conv_d = word_width'(hold_i);
        dac_cfg_pkg::route_imag: conv_d = word_width'(hold_q);
        default:                 conv_d = converter_word;
      endcase
    end
  end
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tog_s           <= 3'b000;
      converter_word  <= '0;
      converter_valid <= 1'b0;
    end
    else
    begin
      tog_s           <= {tog_s[1:0], tog_q};
      converter_word  <= conv_d;
      converter_valid <= cv_d;
    end
  end
endmodule : dac_input_modulator_config

`default_nettype wire

// ---- verif/dac_cfg_props.sv ----
// port assertions for the configuration block
// assumes bind onto dac_input_modulator_config, outputs settle two mclk edges after a write
`timescale 1ns/1ns
`default_nettype none
module dac_cfg_props (
  input wire logic              mclk,
  input wire logic              rst_b,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic [7:0]        reg_rdata,
  input wire logic              word_clk_out,
  input wire logic              word_clk_oe_b,
  input wire logic              recovery_active,
  input wire logic signed [4:0] word_clock_offset,
  input wire logic [1:0]        mix_rate_select,
  input wire logic              dual_channel_mixing
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  chk_mix_rate:
    assert property (reg_wr && reg_addr == 8'h03 |-> ##2
      mix_rate_select == $past(reg_wdata[3:2], 2)) else $error("mix rate wrong");
  chk_dual_mix:
    assert property (reg_wr && reg_addr == 8'h03 |-> ##2
      dual_channel_mixing == $past(reg_wdata[5], 2)) else $error("dual mix wrong");
  chk_offset_sign:
    assert property (reg_wr && reg_addr == 8'h05 |-> ##2 word_clock_offset ==
      {$past(reg_wdata[7], 2), $past(reg_wdata[7:4], 2)}) else $error("offset wrong");
  chk_recovery_gate:
    assert property (reg_wr && reg_addr == 8'h02 |-> ##2 recovery_active ==
      ($past(reg_wdata[2], 2) & ~$past(reg_wdata[3], 2))) else $error("recovery wrong");
  chk_clk_dir:
    assert property (reg_wr && reg_addr == 8'h02 |-> ##2
      word_clk_oe_b == ~$past(reg_wdata[3], 2)) else $error("direction wrong");
  chk_clk_idle:
    assert property (word_clk_oe_b && $past(word_clk_oe_b, 2) |-> !word_clk_out)
      else $error("word clock driven as input");
  chk_rev_read:
    assert property (reg_rd && reg_addr == 8'h0d |=>
      reg_rdata[3:0] == dac_cfg_pkg::revision_default) else $error("revision wrong");
  chk_unmapped_read:
    assert property (reg_rd && !(reg_addr inside {8'h02, 8'h03, 8'h05, 8'h0d}) |=>
      reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule : dac_cfg_props
bind dac_input_modulator_config dac_cfg_props u_dac_cfg_props (.mclk(mclk), .rst_b(rst_b),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .word_clk_out(word_clk_out), .word_clk_oe_b(word_clk_oe_b),
  .recovery_active(recovery_active), .word_clock_offset(word_clock_offset),
  .mix_rate_select(mix_rate_select), .dual_channel_mixing(dual_channel_mixing));
`default_nettype wire

// ---- verif/data_source_model.sv ----
// sample word source on the link clock
// assumes the bench hands it the port mode, lane polarity and capture edge
`timescale 1ns/1ns
`default_nettype none
module data_source_model (
  input wire logic        link_clk,
  input wire logic        en,
  input wire logic        one_port,
  input wire logic        lane_pol,
  input wire logic        edge_pol,
  input wire logic [15:0] i_word,
  input wire logic [15:0] q_word,
  output logic [15:0]     port1_data = 16'h0000,
  output logic [15:0]     port2_data = 16'h0000,
  output logic            lane_select_strobe = 1'b0
);
  logic phase = 1'b0;
  // change on the edge the device does not capture on, so data is settled there
  always @(link_clk)
  begin
    if (link_clk == edge_pol)
    begin
      phase <= ~phase;
      if (en && !one_port)
      begin
        port1_data <= i_word;
        port2_data <= q_word;
      end
      else
      begin
        // unused lanes keep moving so a wrong lane choice shows up
        port2_data <= ~port2_data;
        if (en)
        begin
          port1_data <= phase ? q_word : i_word;
          lane_select_strobe <= phase ^ ~lane_pol;
        end
        else
          port1_data <= ~port1_data;
      end
    end
  end
endmodule : data_source_model
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking bench for the configuration block
// assumes mclk at 100 ns and a free running 48 ns link clock
`timescale 1ns/1ns
`default_nettype none
`define CHECK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin num_errors++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb;
  logic        mclk = 1'b0, link_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d_reg = 8'h00, m_reg, o_reg, v;
  logic [15:0] p1, p2, i_word = 16'h0000, q_word = 16'h0000, cw;
  logic        strobe, rec, dual, sb, cv, oe_b, wco, w0, src_en = 1'b0;
  logic signed [4:0] offs;
  logic [1:0]  mix;
  logic [31:0] seed = 32'h11e6;
  int          num_errors = 0, cmp_count = 0, n;
  always #50 mclk = ~mclk;
  initial #7 forever #24 link_clk = ~link_clk;
  dac_input_modulator_config #(.word_width(16), .clk_div(4)) u_dac_input_modulator_config (
    .mclk(mclk), .rst_b(rst_b), .link_clk(link_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .port1_data(p1),
    .port2_data(p2), .lane_select_strobe(strobe), .word_clk_in(link_clk), .word_clk_out(wco),
    .word_clk_oe_b(oe_b), .recovery_active(rec), .word_clock_offset(offs),
    .mix_rate_select(mix), .dual_channel_mixing(dual), .sideband_reject_lower(sb),
    .converter_word(cw), .converter_valid(cv));
  data_source_model u_data_source_model (.link_clk(link_clk), .en(src_en),
    .one_port(d_reg[6]), .lane_pol(d_reg[1]), .edge_pol(d_reg[4]), .i_word(i_word),
    .q_word(q_word), .port1_data(p1), .port2_data(p2), .lane_select_strobe(strobe));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // real and imaginary routes pass the lanes, since no mixer sits in this block
  function automatic logic [15:0] exp_word(input logic [7:0] d, m, input logic [15:0] i, q);
    logic [15:0] w;
    w = m[7] ? q : i;
    w[15] = w[15] ^ d[7];
    return w;
  endfunction : exp_word
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= x;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] x);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 x = reg_rdata;
  endtask : rd
  task automatic wrap_up;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    wrap_up();
  end
  initial
  begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    foreach (m_reg[b])
    begin
      rd(8'h02 + 8'(b % 4), v);
      `CHECK("reset value", 8'h00, v)
    end
    wr(8'h0d, 8'hff);
    rd(8'h0d, v);
    `CHECK("revision", dac_cfg_pkg::revision_default, v[3:0])
    src_en <= 1'b1;
    // route in k[1:0] and mix rate in k[3:2], so every code is visited
    for (int k = 0; k < 16; k++)
    begin
      seed = lfsr(seed);
      d_reg = seed[7:0];
      o_reg = seed[15:8];
      m_reg = {k[1], seed[22], k[0], seed[20], k[3:2], seed[17:16]};
      i_word <= seed[31:16];
      q_word <= seed[15:0] ^ 16'h5a5a;
      wr(8'h02, d_reg);
      wr(8'h03, m_reg);
      wr(8'h05, o_reg);
      repeat (2) @(posedge mclk);
      #1 `CHECK("mix", m_reg[3:2], mix)
      `CHECK("dual", m_reg[5], dual)
      `CHECK("sideband", m_reg[5] & m_reg[4], sb)
      `CHECK("offset", {o_reg[7], o_reg[7:4]}, offs)
      `CHECK("recovery", d_reg[2] & ~d_reg[3], rec)
      `CHECK("oe_b", ~d_reg[3], oe_b)
      rd(8'h02, v);
      `CHECK("data reg", d_reg, v)
      rd(8'h03, v);
      `CHECK("mod reg", m_reg, v)
      rd(8'h05, v);
      `CHECK("offset reg", o_reg, v)
      // driven word clock turns over once in any clk_div (4) edges, else it rests low
      w0 = wco;
      repeat (4) @(posedge mclk);
      #1 `CHECK("word clock", d_reg[3] ? ~w0 : 1'b0, wco)
      repeat (30) @(posedge mclk);
      n = 0;
      do
      begin
        @(posedge mclk);
        #1 n++;
      end while (cv !== 1'b1 && n < 40);
      `CHECK("valid", 1'b1, cv)
      `CHECK("word", exp_word(d_reg, m_reg, i_word, q_word), cw)
    end
    wrap_up();
  end
endmodule : tb
`default_nettype wire
